//--- rtl/lgpm_pkg.sv
// constants and types of the local to global page mapper
// Summary of operation
// RULE1: local 0x8000-0xBFFF maps a 16KB flash block chosen by program page
// RULE2: program page index resets to 0xFE
// RULE3: local 0xC000-0xFFFF always maps to program page 0xFF
// RULE4: far-call/far-return page write completes before instruction ends
// RULE5: program page readable/writable by bus, writable by far-call/return
// RULE6: local 0x1000-0x1FFF maps a 4KB RAM block chosen by RAM page
// RULE7: RAM page 0x00 reaches register space, so writes go there
// RULE8: RAM page index resets to 0xFD
// RULE9: local 0x2000-0x2FFF always maps to RAM page 0xFE
// RULE10: local 0x3000-0x3FFF always maps to RAM page 0xFF
// RULE11: local 0x0800-0x0BFF maps a 1KB data flash block by page index
// RULE12: data flash page index resets to 0xFE
// RULE13: local 0x0C00-0x0FFF always maps to data flash page 0xFF
// RULE14: debug tables visible only in debug-space read/write cycles
// RULE15: in active debug, debug space appears at local 0xFF00-0xFFFF
// RULE16: in active debug, resources sharing debug space are hidden
// RULE17: active debug with program page 0xFF also shows 0xBF00-0xBFFF
// RULE18: cpu global instructions use global page as bits 22:16
// RULE19: debug global page supplies bits 22:16 for debug global accesses
// RULE20: debug local accesses use same page registers and expansion
// RULE21: single-chip mode: no external accesses
// RULE22: 7-bit global page selects one of 128 64KB pages
// RULE23: unpaged local addresses map to fixed global locations
// RULE24: window address = region base + page*size + window offset
package lgpm_pkg;
  localparam logic [15:0] PROG_PAGE_OFS  = 16'h0015;
  localparam logic [15:0] RAM_PAGE_OFS   = 16'h0016;
  localparam logic [15:0] DF_PAGE_OFS    = 16'h0017;
  localparam logic [15:0] GLOB_PAGE_OFS  = 16'h0010;
  localparam logic [15:0] DBG_GLOB_PAGE_OFS = 16'hFF08;
  localparam logic [7:0]  PROG_PAGE_RST  = 8'hFE;
  localparam logic [7:0]  RAM_PAGE_RST   = 8'hFD;
  localparam logic [7:0]  DF_PAGE_RST    = 8'hFE;
  localparam logic [6:0]  GLOB_PAGE_RST  = 7'h00;
  localparam logic [7:0]  FIXED_HI_PAGE  = 8'hFF;
  localparam logic [7:0]  FIXED_LO_PAGE  = 8'hFE;
  localparam logic [22:0] FLASH_BASE     = 23'h40_0000;
  localparam logic [22:0] RAM_BASE       = 23'h00_0000;
  localparam logic [22:0] DF_BASE        = 23'h10_0000;
  localparam logic [22:0] UNPAGED_BASE   = 23'h00_0000;
  localparam logic [22:0] DBG_GLOBAL_BASE = 23'h7F_FF00;
  localparam logic [15:0] REG_SPACE_TOP  = 16'h0800;

  typedef enum logic [1:0] {
    LGPM_SRC_CPU = 2'b00,
    LGPM_SRC_DBG = 2'b01
  } lgpm_src_t;

  typedef enum logic [1:0] {
    LGPM_MODE_LOCAL  = 2'b00,
    LGPM_MODE_GLOBAL = 2'b01
  } lgpm_mode_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        src_dbg;
    logic        global_op;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } lgpm_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        dbg_space;
    logic        reg_space;
    logic [22:0] gaddr;
  } lgpm_map_t;
endpackage

//--- rtl/lgpm_page_regs.sv
// page index registers of the mapper
`timescale 1ns/1ps
module lgpm_page_regs
  import lgpm_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire lgpm_req_t  req_in,
  input  wire logic       hit_in,
  input  wire logic       far_wr_in,
  input  wire logic [7:0] far_page_in,
  output logic [7:0]      prog_page_out,
  output logic [7:0]      ram_page_out,
  output logic [7:0]      df_page_out,
  output logic [6:0]      gl_page_out,
  output logic [6:0]      dbg_gl_page_out,
  output logic [7:0]      rdata_out
);
  logic [7:0] prog_q, prog_d, ram_q, ram_d, df_q, df_d;
  logic [6:0] gp_q, gp_d, dgp_q, dgp_d;
  logic [7:0] rd_q, rd_d;
  logic       wr;

  always_comb begin
    wr     = req_in.valid & req_in.write & hit_in;
    prog_d = prog_q;
    ram_d  = ram_q;
    df_d   = df_q;
    gp_d   = gp_q;
    dgp_d  = dgp_q;
    rd_d   = rd_q;
    // RULE5 RULE20 bus register access
    if (wr && req_in.addr == PROG_PAGE_OFS) begin
      prog_d = req_in.wdata;
    end
    if (wr && req_in.addr == RAM_PAGE_OFS) begin
      ram_d = req_in.wdata;
    end
    if (wr && req_in.addr == DF_PAGE_OFS) begin
      df_d = req_in.wdata;
    end
    if (wr && req_in.addr == GLOB_PAGE_OFS) begin
      gp_d = req_in.wdata[6:0];
    end
    if (wr && req_in.src_dbg && req_in.addr == DBG_GLOB_PAGE_OFS) begin
      dgp_d = req_in.wdata[6:0];
    end
    // RULE4 far-call write wins, ready next cycle
    if (far_wr_in) begin
      prog_d = far_page_in;
    end
    if (req_in.valid && !req_in.write && hit_in) begin
      unique case (req_in.addr)
        PROG_PAGE_OFS: rd_d = prog_q;
        RAM_PAGE_OFS:  rd_d = ram_q;
        DF_PAGE_OFS:   rd_d = df_q;
        GLOB_PAGE_OFS: rd_d = {1'b0, gp_q};
        DBG_GLOB_PAGE_OFS: rd_d = {1'b0, dgp_q};
        default:       rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // RULE2 RULE8 RULE12 reset pages
      prog_q <= PROG_PAGE_RST;
      ram_q  <= RAM_PAGE_RST;
      df_q   <= DF_PAGE_RST;
      gp_q   <= GLOB_PAGE_RST;
      dgp_q  <= GLOB_PAGE_RST;
      rd_q   <= 8'h00;
    end else begin
      prog_q <= prog_d;
      ram_q  <= ram_d;
      df_q   <= df_d;
      gp_q   <= gp_d;
      dgp_q  <= dgp_d;
      rd_q   <= rd_d;
    end
  end

  assign prog_page_out = prog_q;
  assign ram_page_out  = ram_q;
  assign df_page_out   = df_q;
  assign gl_page_out     = gp_q;
  assign dbg_gl_page_out = dgp_q;
  assign rdata_out     = rd_q;
endmodule

//--- rtl/lgpm_expand.sv
// combinational local to global expansion
`timescale 1ns/1ps
module lgpm_expand
  import lgpm_pkg::*;
(
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  prog_page_in,
  input  wire logic [7:0]  ram_page_in,
  input  wire logic [7:0]  df_page_in,
  output logic [22:0]      gaddr_out,
  output logic             reg_space_out
);
  // RULE24 base + page*size + offset
  function automatic logic [22:0] win(input logic [22:0] base,
                                      input logic [7:0] page,
                                      input logic [13:0] ofs,
                                      input int unsigned sh);
    logic [22:0] p;
    p = 23'(page) << sh;
    return base + p + 23'(ofs);
  endfunction

  always_comb begin
    gaddr_out     = UNPAGED_BASE + 23'(addr_in);
    reg_space_out = 1'b0;
    // RULE23 unpaged register space
    if (addr_in < REG_SPACE_TOP) begin
      reg_space_out = 1'b1;
    // RULE11 data flash window
    end else if (addr_in[15:10] == 6'b000010) begin
      gaddr_out = win(DF_BASE, df_page_in, {4'h0, addr_in[9:0]}, 10);
    // RULE13 fixed data flash page
    end else if (addr_in[15:10] == 6'b000011) begin
      gaddr_out = win(DF_BASE, FIXED_HI_PAGE, {4'h0, addr_in[9:0]}, 10);
    // RULE6 RULE7 ram window, page 0 hits registers at 0x1000-0x17FF only
    end else if (addr_in[15:12] == 4'h1) begin
      gaddr_out = win(RAM_BASE, ram_page_in, {2'b00, addr_in[11:0]}, 12);
      reg_space_out = (ram_page_in == 8'h00) && (addr_in[11:0] < 12'h800);
    // RULE9 fixed ram page
    end else if (addr_in[15:12] == 4'h2) begin
      gaddr_out = win(RAM_BASE, FIXED_LO_PAGE, {2'b00, addr_in[11:0]}, 12);
    // RULE10 fixed ram page
    end else if (addr_in[15:12] == 4'h3) begin
      gaddr_out = win(RAM_BASE, FIXED_HI_PAGE, {2'b00, addr_in[11:0]}, 12);
    // RULE1 program window
    end else if (addr_in[15:14] == 2'b10) begin
      gaddr_out = win(FLASH_BASE, prog_page_in, addr_in[13:0], 14);
    // RULE3 fixed program page
    end else if (addr_in[15:14] == 2'b11) begin
      gaddr_out = win(FLASH_BASE, FIXED_HI_PAGE, addr_in[13:0], 14);
    end else begin
      gaddr_out = win(FLASH_BASE, FIXED_LO_PAGE - 8'h1, addr_in[13:0], 14);
    end
  end
endmodule

//--- rtl/lgpm_top.sv
// local to global page mapper top
`timescale 1ns/1ps
module lgpm_top
  import lgpm_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire lgpm_req_t   cpu_req_in,
  input  wire lgpm_req_t   dbg_req_in,
  input  wire logic        far_wr_in,
  input  wire logic [7:0]  far_page_in,
  input  wire logic        dbg_active_in,
  input  wire logic        dbg_space_cycle_in,
  input  wire logic        dbg_fw_global_in,
  output lgpm_map_t        map_out,
  output logic             ext_access_out,
  output logic [7:0]       rdata_out,
  output logic [7:0]       prog_page_out
);
  lgpm_req_t   req;
  logic        hit;
  lgpm_req_t   reg_req;
  logic [7:0]  pp, ram_pg, ep, rd;
  logic [6:0]  gp, dgp;
  logic [22:0] lg;
  logic        lreg;
  lgpm_map_t   map_q, map_d;

  // cpu has priority; debug only when cpu idle
  always_comb begin
    req = cpu_req_in.valid ? cpu_req_in : dbg_req_in;
    hit = !req.global_op;
  end

  lgpm_page_regs u_regs (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .req_in          (reg_req),
    .hit_in          (hit),
    .far_wr_in       (far_wr_in),
    .far_page_in     (far_page_in),
    .prog_page_out   (pp),
    .ram_page_out    (ram_pg),
    .df_page_out     (ep),
    .gl_page_out     (gp),
    .dbg_gl_page_out (dgp),
    .rdata_out     (rd)
  );

  // RULE20 same expansion for both masters
  lgpm_expand u_exp (
    .addr_in       (req.addr),
    .prog_page_in  (pp),
    .ram_page_in   (ram_pg),
    .df_page_in    (ep),
    .gaddr_out     (lg),
    .reg_space_out (lreg)
  );

  // RULE7 register decode on global address
  always_comb begin
    reg_req      = req;
    reg_req.addr = lreg ? lg[15:0] : req.addr;
  end

  always_comb begin
    map_d.valid     = req.valid;
    map_d.write     = req.write;
    map_d.gaddr     = lg;
    map_d.reg_space = lreg;
    map_d.dbg_space = 1'b0;
    if (req.global_op) begin
      map_d.reg_space = 1'b0;
      // RULE19 debug global page for debug accesses
      if (req.src_dbg || dbg_fw_global_in) begin
        map_d.gaddr = {dgp, req.addr};
      // RULE18 RULE22 cpu global page
      end else begin
        map_d.gaddr = {gp, req.addr};
      end
    // RULE14 RULE15 RULE16 debug overlay only in active debug cycles
    end else if (dbg_active_in && dbg_space_cycle_in &&
                 req.addr[15:8] == 8'hFF) begin
      map_d.dbg_space = 1'b1;
      map_d.gaddr     = DBG_GLOBAL_BASE + 23'(req.addr[7:0]);
    // RULE17 mirror when program page is 0xFF
    end else if (dbg_active_in && dbg_space_cycle_in &&
                 pp == FIXED_HI_PAGE && req.addr[15:8] == 8'hBF) begin
      map_d.dbg_space = 1'b1;
      map_d.gaddr     = DBG_GLOBAL_BASE + 23'(req.addr[7:0]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      map_q <= '0;
    end else begin
      map_q <= map_d;
    end
  end

  assign map_out       = map_q;
  // RULE21 single-chip: never external
  assign ext_access_out = 1'b0;
  assign rdata_out     = rd;
  assign prog_page_out = pp;
endmodule

//--- bench/lgpm_mst.sv
// cpu and debug master model driving the mapper
`timescale 1ns/1ps
module lgpm_mst
  import lgpm_pkg::*;
(
  input  wire logic  clk_in,
  output lgpm_req_t  cpu_out = '0,
  output lgpm_req_t  dbg_out = '0,
  output logic       far_wr_out = 1'b0,
  output logic [7:0] far_page_out = 8'h00
);
  // one byte access; answer is settled at the releasing edge
  task automatic acc(input logic d, w, g, input logic [15:0] a,
                     input logic [7:0] v);
    lgpm_req_t r;
    r = {1'b1, w, d, g, a, v};
    @(negedge clk_in);
    if (d) dbg_out = r;
    else cpu_out = r;
    @(negedge clk_in);
    // released bus keeps inverted leftovers, never a clean zero
    if (d) dbg_out = {1'b0, ~r[26:0]};
    else cpu_out = {1'b0, ~r[26:0]};
  endtask
  // far-call page write, one cycle pulse
  task automatic far(input logic [7:0] p);
    @(negedge clk_in);
    far_wr_out = 1'b1;
    far_page_out = p;
    @(negedge clk_in);
    far_wr_out = 1'b0;
    far_page_out = ~p;
  endtask
endmodule

//--- bench/lgpm_top_chk.sv
// port assertions of the page mapper
`timescale 1ns/1ps
module lgpm_top_chk
  import lgpm_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire lgpm_req_t  cpu_req_in,
  input wire logic       far_wr_in,
  input wire logic [7:0] far_page_in,
  input wire logic       dbg_active_in,
  input wire logic       dbg_space_cycle_in,
  input wire logic       dbg_fw_global_in,
  input wire lgpm_map_t  map_out,
  input wire logic [7:0] prog_page_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // debug mode kept out of the window checks
  logic        loc;
  logic [15:0] a;
  assign loc = cpu_req_in.valid && !cpu_req_in.global_op && !dbg_active_in;
  assign a   = cpu_req_in.addr;
  property p_prog;
    loc && a[15:14] == 2'b10 && !far_wr_in |=>
      map_out.gaddr == FLASH_BASE + {$past(prog_page_out), $past(a[13:0])};
  endproperty
  a_prog: assert property (p_prog) else $error("prog window");
  property p_hi;
    loc && a[15:14] == 2'b11 |=> map_out.gaddr == {9'h1FF, $past(a[13:0])};
  endproperty
  a_hi: assert property (p_hi) else $error("fixed flash");
  property p_ram;
    loc && a[15:13] == 3'b001 |=>
      map_out.gaddr == 23'h0FE000 + $past(a[12:0]);
  endproperty
  a_ram: assert property (p_ram) else $error("fixed ram");
  property p_df;
    loc && a[15:10] == 6'h03 |=> map_out.gaddr == {13'h04FF, $past(a[9:0])};
  endproperty
  a_df: assert property (p_df) else $error("fixed data flash");
  property p_glob;
    cpu_req_in.valid && cpu_req_in.global_op && !dbg_active_in &&
      !dbg_fw_global_in |=> map_out.gaddr[15:0] == $past(a);
  endproperty
  a_glob: assert property (p_glob) else $error("global low");
  property p_dbg;
    loc == 1'b0 && cpu_req_in.valid && !cpu_req_in.global_op &&
      dbg_space_cycle_in && a[15:8] == 8'hFF |=>
      map_out.dbg_space && map_out.gaddr[22:8] == 15'h7FFF;
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug overlay");
  property p_hide;
    !dbg_space_cycle_in |=> !map_out.dbg_space;
  endproperty
  a_hide: assert property (p_hide) else $error("debug shown");
  property p_far;
    far_wr_in |=> prog_page_out == $past(far_page_in);
  endproperty
  a_far: assert property (p_far) else $error("far write");
  property p_rst;
    $fell(rst_in) |-> prog_page_out == PROG_PAGE_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("page reset");
endmodule
bind lgpm_top lgpm_top_chk i_lgpm_top_chk(.clk_in(clk_in), .rst_in(rst_in),
  .cpu_req_in(cpu_req_in), .far_wr_in(far_wr_in), .map_out(map_out),
  .far_page_in(far_page_in), .dbg_active_in(dbg_active_in),
  .dbg_space_cycle_in(dbg_space_cycle_in), .prog_page_out(prog_page_out),
  .dbg_fw_global_in(dbg_fw_global_in));

//--- bench/lgpm_top_tb.sv
// self-checking bench of the page mapper
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module lgpm_top_tb;
  import lgpm_pkg::*;
  logic       clk_in = 1'b0, rst_in = 1'b1;
  logic       act = 1'b0, spc = 1'b0, fwg = 1'b0, fw, ext;
  logic [7:0] fp, rd_q, pp;
  lgpm_req_t  cpu, dbg;
  lgpm_map_t  map;
  int         fails = 0, checks_done = 0;
  always #4 clk_in = ~clk_in;
  lgpm_top i_lgpm_top(.clk_in(clk_in), .rst_in(rst_in), .cpu_req_in(cpu),
    .dbg_req_in(dbg), .far_wr_in(fw), .far_page_in(fp), .map_out(map),
    .dbg_active_in(act), .dbg_space_cycle_in(spc), .dbg_fw_global_in(fwg),
    .ext_access_out(ext), .rdata_out(rd_q), .prog_page_out(pp));
  lgpm_mst i_lgpm_mst(.clk_in(clk_in), .cpu_out(cpu), .dbg_out(dbg),
    .far_wr_out(fw), .far_page_out(fp));
  task automatic rd(input logic d, input logic [15:0] a, input logic [7:0] e);
    i_lgpm_mst.acc(d, 1'b0, 1'b0, a, 8'h00);
    `CHK("rdata", e, rd_q)
  endtask
  task automatic mp(input logic d, g, input logic [15:0] a,
                    input logic [22:0] e);
    i_lgpm_mst.acc(d, 1'b0, g, a, 8'h00);
    `CHK("gaddr", e, map.gaddr)
    `CHK("map_rw", 2'b10, {map.valid, map.write})
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // run takes about 66 cycles; ample margin
  initial begin
    #20000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    `CHK("prog_page", 8'hFE, pp)
    rd(0, PROG_PAGE_OFS, 8'hFE);
    rd(1, RAM_PAGE_OFS, 8'hFD);
    rd(0, DF_PAGE_OFS, 8'hFE);
    mp(0, 0, 16'h8000, 23'h7F8000);
    mp(0, 0, 16'hC123, 23'h7FC123);
    mp(0, 0, 16'h3FFF, 23'h0FFFFF);
    mp(0, 0, 16'h0010, 23'h000010);
    $display("t1 end");
    i_lgpm_mst.acc(0, 1, 0, PROG_PAGE_OFS, 8'h03);
    i_lgpm_mst.acc(1, 1, 0, RAM_PAGE_OFS, 8'h00);
    i_lgpm_mst.acc(0, 1, 0, DF_PAGE_OFS, 8'h05);
    rd(0, PROG_PAGE_OFS, 8'h03);
    mp(0, 0, 16'h8123, 23'h40C123);
    mp(0, 0, 16'h2001, 23'h0FE001);
    mp(0, 0, 16'h0801, 23'h101401);
    mp(0, 0, 16'h0C01, 23'h13FC01);
    mp(0, 0, 16'h1010, 23'h000010);
    `CHK("reg_space", 1'b1, map.reg_space)
    i_lgpm_mst.acc(0, 1, 0, 16'h1017, 8'h06);
    rd(0, DF_PAGE_OFS, 8'h06);
    $display("t2 end");
    i_lgpm_mst.far(8'h21);
    `CHK("prog_page", 8'h21, pp)
    mp(1, 0, 16'h8000, 23'h484000);
    i_lgpm_mst.acc(0, 1, 0, GLOB_PAGE_OFS, 8'h14);
    mp(0, 1, 16'h5000, 23'h145000);
    $display("t3 end");
    act = 1'b1;
    spc = 1'b1;
    i_lgpm_mst.acc(1, 1, 0, DBG_GLOB_PAGE_OFS, 8'h33);
    mp(1, 1, 16'h1234, 23'h331234);
    fwg = 1'b1;
    mp(0, 1, 16'h0456, 23'h330456);
    fwg = 1'b0;
    mp(0, 0, 16'hFF10, 23'h7FFF10);
    `CHK("dbg_space", 1'b1, map.dbg_space)
    i_lgpm_mst.far(8'hFF);
    mp(0, 0, 16'hBF20, 23'h7FFF20);
    `CHK("dbg_space", 1'b1, map.dbg_space)
    spc = 1'b0;
    mp(0, 0, 16'hFF10, 23'h7FFF10);
    `CHK("dbg_space", 1'b0, map.dbg_space)
    `CHK("ext_access", 1'b0, ext)
    $display("t4 end");
    wrap_up();
  end
endmodule
